// *** logic/timer1_control_logic.v ***
// Functional notes
// - The 16-bit count advances only while the run bit is one and holds while it is zero.
// - With idle-halt set the timer freezes while the processor is idle, otherwise it keeps going.
// - The two-bit prescale field divides the input clock by 1, 8, 64 or 256.
// - On the external source the sync bit selects a retimed edge or the raw sampled edge; on the internal source it is ignored.
// - The source bit picks rising edges of the external pin when one and the peripheral clock when zero.
// - While running on the external source with sync set, software writes to the count are dropped.
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "timer_one_map.vh"

module timer1_control_logic (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    input  wire        cpu_idle,
    input  wire        timer_one_ext_clock_pin,
    output reg  [15:0] timer_one_count,
    output reg         timer_running
);

    // Register file
    reg  [15:0] timer_one_control_reg;
    reg  [15:0] count_reg;
    reg  [7:0]  prescale_reg;

    // Data-phase bookkeeping for writes
    reg         wr_pending_reg;
    reg  [`ADDR_WIDTH-1:0] wr_addr_reg;

    // External pin synchroniser and edge history
    reg         ext_meta_reg;
    reg         ext_sync_reg;
    reg         ext_retime_reg;
    reg         ext_prev_reg;

    // Control fields
    wire        timer_run;
    wire        idle_halt_select;
    wire        gated_accumulate_enable;
    wire [1:0]  input_prescale_select;
    wire        ext_clock_sync_select;
    wire        count_source_select;

    assign timer_run               = timer_one_control_reg[`RUN_BIT];
    assign idle_halt_select        = timer_one_control_reg[`IDLE_HALT_BIT];
    assign gated_accumulate_enable = timer_one_control_reg[`GATE_BIT];
    assign input_prescale_select   = timer_one_control_reg[`PRESCALE_HI:`PRESCALE_LO];
    assign ext_clock_sync_select   = timer_one_control_reg[`SYNC_BIT];
    assign count_source_select     = timer_one_control_reg[`SOURCE_BIT];

    // Bus decode
    wire        addr_phase;
    wire [`ADDR_WIDTH-1:0] addr_low;
    wire        rd_req;
    wire        wr_req;

    assign addr_phase = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
    assign addr_low   = haddr[`ADDR_WIDTH-1:0];
    assign rd_req     = addr_phase && !hwrite;
    assign wr_req     = addr_phase && hwrite;

    // Data-phase write strobes
    wire        ctrl_write;
    wire        count_write;
    wire        count_write_locked;

    assign ctrl_write  = wr_pending_reg && (wr_addr_reg == `CTRL_ADDR);
    assign count_write = wr_pending_reg && (wr_addr_reg == `COUNT_ADDR);

    // External synchronous counter mode makes the count read-only while the run bit is set
    assign count_write_locked = count_source_select && ext_clock_sync_select && timer_run;

    // Input event selection
    wire        raw_edge;
    wire        retimed_edge;
    reg         ext_event;
    reg         int_event;
    reg         source_event;
    wire        idle_freeze;
    wire        active;
    reg  [7:0]  prescale_term;
    wire        prescale_out;

    // Raw edge comes straight off the two-flop synchroniser; the retimed one costs a cycle more
    assign raw_edge     = ext_sync_reg && !ext_retime_reg;
    assign retimed_edge = ext_retime_reg && !ext_prev_reg;

    // Both external paths pass the mandatory synchroniser; here the sync bit adds latency, and while running it also locks count writes
    always @* begin
        ext_event = raw_edge;
        if (ext_clock_sync_select) begin
            ext_event = retimed_edge;
        end else begin
            ext_event = raw_edge;
        end
    end

    // Gate pin shares the external pin; only meaningful on the internal source
    always @* begin
        int_event = 1'b1;
        if (gated_accumulate_enable) begin
            int_event = ext_sync_reg;
        end else begin
            int_event = 1'b1;
        end
    end

    // Internal source offers one event per hclk (with gating on, only while the synchronised pin is high), external one per seen rising edge
    always @* begin
        source_event = int_event;
        if (count_source_select) begin
            source_event = ext_event;
        end else begin
            source_event = int_event;
        end
    end

    assign idle_freeze = idle_halt_select && cpu_idle;

    assign active = timer_run && !idle_freeze && source_event;

    always @* begin
        case (input_prescale_select)
            `PRESCALE_1:   prescale_term = `TERM_1;
            `PRESCALE_8:   prescale_term = `TERM_8;
            `PRESCALE_64:  prescale_term = `TERM_64;
            default:       prescale_term = `TERM_256;
        endcase
    end

    assign prescale_out = active && (prescale_reg == prescale_term);

    // Read mux
    reg  [31:0] read_value;

    always @* begin
        read_value = 32'h0000_0000;
        if (addr_low == `CTRL_ADDR) begin
            read_value = {16'h0000, timer_one_control_reg};
        end else if (addr_low == `COUNT_ADDR) begin
            read_value = {16'h0000, count_reg};
        end else begin
            read_value = 32'h0000_0000;
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= `HRESP_OKAY;
        end else begin
            // Every register answers in a single data phase
            hreadyout <= 1'b1;
            hresp     <= `HRESP_OKAY;
        end
    end

    // Write address is held for the data phase, when hwdata arrives
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending_reg <= 1'b0;
            wr_addr_reg    <= {`ADDR_WIDTH{1'b0}};
        end else begin
            wr_pending_reg <= wr_req;
            if (wr_req) begin
                wr_addr_reg <= addr_low;
            end
        end
    end

    // Read data is captured at the address phase so it stands through the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_req) begin
            hrdata <= read_value;
        end
    end

    // Control register; unimplemented bits are masked so they always read zero
    reg  [15:0] control_next;

    always @* begin
        control_next = timer_one_control_reg;
        if (ctrl_write) begin
            control_next = hwdata[15:0] & `CTRL_WRITE_MASK;
        end else begin
            control_next = timer_one_control_reg;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_one_control_reg <= `CTRL_RESET;
        end else begin
            timer_one_control_reg <= control_next;
        end
    end

    // External pin synchroniser; only the second flop feeds any logic
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
        end else begin
            ext_meta_reg <= timer_one_ext_clock_pin;
            ext_sync_reg <= ext_meta_reg;
        end
    end

    // Edge history resets low, so a pin already high at reset counts as one edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_retime_reg <= 1'b0;
            ext_prev_reg   <= 1'b0;
        end else begin
            ext_retime_reg <= ext_sync_reg;
            ext_prev_reg   <= ext_retime_reg;
        end
    end

    // Next-state logic for prescaler and count
    reg  [7:0]  prescale_next;
    reg  [15:0] count_next;
    wire        count_load;

    // A write dropped in synchronous external mode must not restart the prescaler either
    assign count_load = count_write && !count_write_locked;

    always @* begin
        prescale_next = prescale_reg;
        if (ctrl_write || count_load) begin
            // Restart on reconfiguration so a new ratio starts clean
            prescale_next = `PRESCALE_RESET;
        end else if (prescale_out) begin
            prescale_next = `PRESCALE_RESET;
        end else if (active) begin
            prescale_next = prescale_reg + `PRESCALE_STEP;
        end else begin
            prescale_next = prescale_reg;
        end
    end

    always @* begin
        count_next = count_reg;
        if (count_load) begin
            // An accepted write wins over a coincident increment
            count_next = hwdata[15:0];
        end else if (prescale_out) begin
            // Wraps from all ones to zero with no overflow flag
            count_next = count_reg + `COUNT_STEP;
        end else begin
            count_next = count_reg;
        end
    end

    // Prescaler
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescale_reg <= `PRESCALE_RESET;
        end else begin
            prescale_reg <= prescale_next;
        end
    end

    // Count register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= `COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    // Mirrors for observation; both trail the internal state by one cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_one_count <= `COUNT_RESET;
        end else begin
            timer_one_count <= count_reg;
        end
    end

    // Registered so the output comes straight from a flop
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_running <= 1'b0;
        end else begin
            timer_running <= timer_run && !idle_freeze;
        end
    end

endmodule

// *** logic/timer_one_map.vh ***
`ifndef TIMER_ONE_MAP_VH
`define TIMER_ONE_MAP_VH

// Register byte addresses
`define CTRL_ADDR           12'h000
`define COUNT_ADDR          12'h004
`define ADDR_WIDTH          12

// Control register field positions
`define RUN_BIT             15
`define IDLE_HALT_BIT       13
`define GATE_BIT            6
`define PRESCALE_HI         5
`define PRESCALE_LO         4
`define SYNC_BIT            2
`define SOURCE_BIT          1

// Writable bits of the control register, all others read as zero
`define CTRL_WRITE_MASK     16'hA076
`define CTRL_RESET          16'h0000
`define COUNT_RESET         16'h0000

// Prescale select codes and their terminal counts
`define PRESCALE_1          2'h0
`define PRESCALE_8          2'h1
`define PRESCALE_64         2'h2
`define PRESCALE_256        2'h3
`define TERM_1              8'h00
`define TERM_8              8'h07
`define TERM_64             8'h3F
`define TERM_256            8'hFF
`define PRESCALE_RESET      8'h00
`define PRESCALE_STEP       8'h01
`define COUNT_STEP          16'h0001

// AHB-Lite encodings
`define HTRANS_NONSEQ       2'h2
`define HTRANS_SEQ          2'h3
`define HRESP_OKAY          1'b0

`endif

// *** testbench/timer1_control_logic_sva.sv ***
`timescale 1ns/10ps
`include "timer_one_map.vh"
module timer1_checker (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire [31:0] hrdata,
    input wire        hresp,
    input wire        cpu_idle,
    input wire [15:0] timer_one_count,
    input wire        timer_running
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    wire         req = hsel && hready && htrans[1];
    logic [15:0] ctl;
    logic        wc, wn, w2, w3;
    // Shadow control; w2/w3 mark where an accepted count write may land
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {ctl, wc, wn, w2, w3} <= '0;
        end else begin
            wc <= req && hwrite && haddr[11:0] == `CTRL_ADDR;
            wn <= req && hwrite && haddr[11:0] == `COUNT_ADDR;
            ctl <= wc ? hwdata[15:0] & `CTRL_WRITE_MASK : ctl;
            w2 <= wn && !(ctl[15] && ctl[2] && ctl[1]);
            w3 <= w2;
        end
    end
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (hresp == `HRESP_OKAY) else $error("hresp not okay");
    a_upper_zero: assert property (hrdata[31:16] == 16'h0) else $error("hrdata upper bits set");
    a_run_state: assert property (
        timer_running == $past(ctl[15] && !(ctl[13] && cpu_idle))) else $error("timer_running wrong");
    a_read_ctrl: assert property (
        req && !hwrite && haddr[11:0] == `CTRL_ADDR |=> hrdata[15:0] == $past(ctl)) else $error("control read");
    a_read_hole: assert property (
        req && !hwrite && haddr[11:0] > `COUNT_ADDR |=> hrdata == 32'h0) else $error("hole read");
    a_count_step: assert property (
        $changed(timer_one_count) && !(w2 || w3) |-> timer_one_count == $past(timer_one_count) + 16'h1)
        else $error("count jumped");
    a_count_hold: assert property (
        $changed(timer_one_count) && !(w2 || w3) |-> $past(timer_running)) else $error("count moved stopped");
endmodule
bind timer1_control_logic timer1_checker u_chk (.*);

// *** testbench/ext_clock_source.sv ***
`timescale 1ns/10ps
module ext_clock_source (
    input  wire  hclk,
    input  wire  en,
    input  wire  lvl,
    output logic pin,
    output int   rises
);
    int ph = 0;
    initial pin = 1'b0;
    initial rises = 0;
    // Changes only every third clock so each level lasts long enough to be seen
    always @(posedge hclk) begin
        ph <= (ph + 1) % 3;
        if (ph == 0) begin
            pin <= en ? !pin : lvl;
            rises <= rises + int'(!pin && (en || lvl));
        end
    end
endmodule

// *** testbench/timer1_control_logic_bench.sv ***
`timescale 1ns/10ps
`include "timer_one_map.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("mismatch t=%0t %h %h", $time, a, b); end end
module timer1_control_logic_bench;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, cpu_idle = 0, en = 0, lvl = 0;
    logic        hreadyout, hresp, pin, run;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
    logic [1:0]  htrans = 0;
    logic [15:0] cnt;
    int          fails = 0, checks = 0, rises, k, p;
    int          div[4] = '{1, 8, 64, 256};
    always #5 hclk = !hclk;
    ext_clock_source u_src (.hclk(hclk), .en(en), .lvl(lvl), .pin(pin), .rises(rises));
    timer1_control_logic u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cpu_idle(cpu_idle),
        .timer_one_ext_clock_pin(pin), .timer_one_count(cnt), .timer_running(run));
    task automatic stop_test(input int f);
        fails += f;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wt();
        int n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            if (++n > 20) stop_test(1);
            @(posedge hclk);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= `HTRANS_NONSEQ;
        hwrite <= w;
        wt();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= v;
        wt();
        d = hrdata;
    endtask
    // Run for k+2 enabled edges, then stop and read the count back
    task automatic win(input logic [15:0] c, input int n);
        xfer(1, `COUNT_ADDR, 0);
        xfer(1, `CTRL_ADDR, c);
        repeat (k) @(posedge hclk);
        xfer(1, `CTRL_ADDR, 0);
        xfer(0, `COUNT_ADDR, 0);
        `CHK(d[15:0], 16'(n))
    endtask
    task automatic ext(input logic [15:0] c, input int n);
        int r0;
        xfer(1, `COUNT_ADDR, 0);
        xfer(1, `CTRL_ADDR, c);
        r0 = rises;
        en <= 1'b1;
        repeat (k) @(posedge hclk);
        en <= 1'b0;
        repeat (20) @(posedge hclk);
        xfer(0, `COUNT_ADDR, 0);
        `CHK(d[15:0], 16'((rises - r0) / n))
        xfer(1, `COUNT_ADDR, 32'h1234);
        xfer(0, `COUNT_ADDR, 0);
        `CHK(d[15:0], c[2] ? 16'((rises - r0) / n) : 16'h1234)
        xfer(1, `CTRL_ADDR, 0);
    endtask
    initial begin
        k = $urandom(15311);
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(0, `CTRL_ADDR, 0);
        `CHK(d, 32'(`CTRL_RESET))
        xfer(1, `CTRL_ADDR, 32'hFFFF7FFF);
        xfer(0, `CTRL_ADDR, 0);
        `CHK(d, 32'h2076)
        xfer(1, 12'h008, 32'h5A5A);
        xfer(0, 12'h008, 0);
        `CHK(d, 32'h0)
        for (p = 0; p < 4; p++) begin
            k = 300 + $urandom % 300;
            win(16'h8000 | 16'(p << 4), (k + 2) / div[p]);
        end
        k = 100;
        win(16'h0030, 0);
        win(16'h8004, 102);
        cpu_idle <= 1'b1;
        win(16'hA000, 0);
        win(16'h8000, 102);
        cpu_idle <= 1'b0;
        lvl <= 1'b1;
        repeat (10) @(posedge hclk);
        win(16'h8040, 102);
        lvl <= 1'b0;
        repeat (10) @(posedge hclk);
        win(16'h8040, 0);
        k = 200 + $urandom % 100;
        ext(16'h8042, 1);
        ext(16'h8016, 8);
        stop_test(0);
    end
endmodule
